// ---- common/ddr_pkg.sv ----
// Purpose: Shared constants and types for the double-data-rate pin register cell.
// Assumes: One system clock; both of its edges are used by the pin registers.
// Notes: Every reset value and size used by more than one file lives here.
package ddr_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int PIN_WIDTH = 8;
  localparam int FIFO_DEPTH = 8;
  localparam int SYNC_STAGES = 2;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic CLEAR_VALUE = 1'b0;
  localparam logic PRESET_VALUE = 1'b1;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_INPUT = 2'b00,
    MODE_OUTPUT = 2'b01,
    MODE_BIDIR = 2'b10,
    MODE_OFF = 2'b11
  } pin_mode_t;

  typedef enum logic [1:0] {
    DIR_IDLE = 2'b00,
    DIR_DRIVE = 2'b01,
    DIR_TURN = 2'b10
  } dir_state_t;

endpackage

// ---- hw/ddr_fifo.sv ----
// Purpose: Small synchronous FIFO standing in the output data path.
// Assumes: One clock, asynchronous active-low reset.
// Notes: Read data come from a register; full and empty are exact.
`timescale 1ns/10ps
module ddr_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic wrValid,
  output logic wrReady,
  input wire logic [WIDTH-1:0] wrData,
  output logic rdValid,
  input wire logic rdReady,
  output logic [WIDTH-1:0] rdData
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_r;
  logic [AW-1:0] rdPtr_r;
  logic [AW:0] count_r;
  logic [WIDTH-1:0] head_r;
  logic headValid_r;
  logic doWrite;
  logic doPop;
  logic loadHead;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  // The head word is held in its own register so that the read data
  // never come straight from the storage array.
  // The count includes the head word, so the FIFO never holds more than DEPTH words.
  assign wrReady = (count_r != DEPTH[AW:0]);
  assign doWrite = wrValid && wrReady;
  assign doPop = rdValid && rdReady;
  assign loadHead = (count_r != {{AW{1'b0}}, headValid_r}) && (!headValid_r || doPop);
  assign rdValid = headValid_r;
  assign rdData = head_r;

  always_ff @(posedge clk) begin
    if (doWrite) begin
      mem[wrPtr_r] <= wrData;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wrPtr_r <= '0;
    end else if (doWrite) begin
      wrPtr_r <= (wrPtr_r == AW'(DEPTH - 1)) ? '0 : wrPtr_r + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdPtr_r <= '0;
    end else if (loadHead) begin
      rdPtr_r <= (rdPtr_r == AW'(DEPTH - 1)) ? '0 : rdPtr_r + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      count_r <= '0;
    end else begin
      count_r <= count_r + (doWrite ? 1'b1 : 1'b0) - (doPop ? 1'b1 : 1'b0);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      head_r <= '0;
      headValid_r <= 1'b0;
    end else if (loadHead) begin
      head_r <= mem[rdPtr_r];
      headValid_r <= 1'b1;
    end else if (doPop) begin
      headValid_r <= 1'b0;
    end
  end

endmodule

// ---- hw/ddr_out_stage.sv ----
// Purpose: Output register pair, clock-driven pin multiplexer and output-enable registers.
// Assumes: Loads on the rising edge of clk; the enable register pair ends on the falling edge.
// Notes: The pin multiplexer is steered by clk itself, so the pin changes twice per period.
`timescale 1ns/10ps
module ddr_out_stage #(
  parameter int WIDTH = 8,
  parameter logic RESET_VALUE = 1'b0
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic syncClear,
  input wire logic load,
  input wire logic [WIDTH-1:0] firstBit,
  input wire logic [WIDTH-1:0] secondBit,
  input wire logic driveReq,
  output logic [WIDTH-1:0] pinOut,
  output logic driveNow
);

  logic [WIDTH-1:0] firstBit_r;
  logic [WIDTH-1:0] secondBit_r;
  logic drivePos_r;
  logic driveNeg_r;

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      firstBit_r <= {WIDTH{RESET_VALUE}};
      secondBit_r <= {WIDTH{RESET_VALUE}};
    end else if (syncClear) begin
      firstBit_r <= {WIDTH{RESET_VALUE}};
      secondBit_r <= {WIDTH{RESET_VALUE}};
    end else if (load) begin
      firstBit_r <= firstBit;
      secondBit_r <= secondBit;
    end
  end

  // High phase carries the first bit, low phase the second.
  assign pinOut = clk ? firstBit_r : secondBit_r;

  // ----------------------------------------------------------------
  // Output-enable registers
  // ----------------------------------------------------------------
  // The rising-edge register meets the logic timing; the falling-edge one
  // delays the enable half a period so the bus turns around cleanly.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      drivePos_r <= 1'b0;
    end else if (syncClear) begin
      drivePos_r <= 1'b0;
    end else begin
      drivePos_r <= driveReq;
    end
  end

  always_ff @(negedge clk or negedge resetn) begin
    if (!resetn) begin
      driveNeg_r <= 1'b0;
    end else if (syncClear) begin
      driveNeg_r <= 1'b0;
    end else begin
      driveNeg_r <= drivePos_r;
    end
  end

  assign driveNow = driveNeg_r;

endmodule

// ---- hw/ddr_io_register_path.sv ----
// What this block does
// - Six registers clock data on both the rising and the falling edge of the clock.
// - In input mode two input registers capture the double-rate data, one on each edge.
// - An input latch stage holds the bit seen while the clock is high so it can be captured.
// - Both captured bits reach the logic side aligned to the rising edge; the falling setting only pairs them at the falling edge first.
// - In output mode two output registers load the two logic-side streams on the rising edge.
// - The two output values are multiplexed by the clock so the pin toggles at twice the clock rate.
// - The pin carries the first bit while the clock is high and the second while it is low.
// - Bidirectional mode joins the input capture and the output drive on one shared pin.
// - A falling-edge output-enable register keeps the enable off until the falling edge after its request.
// - The output clock enable defaults high so the output registers load on every active edge; here ceOut has no default and loads need outLoad.
// - With the output clock enable low the output registers keep their contents.
// - The tristate control is active high by default and can be inverted to active low.
// - Without strobe phase-shift circuitry the read strobe is ignored and capture uses the clock.
// - Latch capture is offered only on data pins and the strobe input only on strobe pins.
// - On strobe pins the synchronised strobe edge qualifies the capture valid flag, not the data input registers.
// - All capture and output data registers share one clear or preset choice and also have a synchronous reset.
//
// Purpose: Double-data-rate pin register cell between logic cells and an external memory bus.
// Assumes: clk at 100 MHz; both edges used; pins already resolved into in, out and enable.
// Notes: The output side is buffered by a FIFO so the logic side sees valid/ready back-pressure.
`timescale 1ns/10ps
module ddr_io_register_path #(
  parameter int WIDTH = ddr_pkg::PIN_WIDTH,
  parameter int DEPTH = ddr_pkg::FIFO_DEPTH,
  parameter bit USE_PRESET = 1'b0,
  parameter bit DATA_PIN = 1'b1,
  parameter bit STROBE_PIN = 1'b0,
  parameter bit PHASE_SHIFT_BANK = 1'b1,
  parameter bit ALIGN_FALLING = 1'b0,
  parameter bit OE_ACTIVE_LOW = 1'b0
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic syncClear,
  input wire logic [1:0] pinMode,
  input wire logic [WIDTH-1:0] padIn,
  output logic [WIDTH-1:0] padOut,
  output logic padOeN,
  input wire logic strobeIn,
  input wire logic useStrobe,
  input wire logic ceIn,
  input wire logic ceOut,
  input wire logic triCtl,
  input wire logic wrValid,
  output logic wrReady,
  input wire logic [WIDTH-1:0] wrFirst,
  input wire logic [WIDTH-1:0] wrSecond,
  output logic [WIDTH-1:0] rdFirst,
  output logic [WIDTH-1:0] rdSecond,
  output logic rdValid,
  output logic driving
);

  // ----------------------------------------------------------------
  // Shared reset choice
  // ----------------------------------------------------------------
  // One constant per cell: every capture and output data register takes the same clear or preset.
  localparam logic RST_BIT = USE_PRESET ? ddr_pkg::PRESET_VALUE : ddr_pkg::CLEAR_VALUE;
  localparam logic [WIDTH-1:0] RST_WORD = {WIDTH{RST_BIT}};
  localparam bit STROBE_ALLOWED = STROBE_PIN && PHASE_SHIFT_BANK;
  localparam bit LATCH_ALLOWED = DATA_PIN;

  ddr_pkg::pin_mode_t mode;
  ddr_pkg::dir_state_t dirState_r;
  ddr_pkg::dir_state_t dirState_nxt;
  logic inputActive;
  logic outputActive;
  logic [WIDTH-1:0] riseCap_r;
  logic [WIDTH-1:0] fallCap_r;
  logic [WIDTH-1:0] highHold_r;
  logic [WIDTH-1:0] alignFirst_r;
  logic [WIDTH-1:0] alignSecond_r;
  logic [WIDTH-1:0] pairFirst_r;
  logic [WIDTH-1:0] pairSecond_r;
  logic pairValid_r;
  logic [ddr_pkg::SYNC_STAGES:0] strobeSync_r;
  logic strobeEdge;
  logic captureEn;
  logic alignEn;
  logic fifoValid;
  logic fifoReady;
  logic [2*WIDTH-1:0] fifoData;
  logic outLoad;
  logic driveReq;
  logic driveNow;
  logic [WIDTH-1:0] stageOut;
  logic triActive;

  assign mode = ddr_pkg::pin_mode_t'(pinMode);

  // Off mode parks both paths, so a spare cell neither captures nor drives.
  always_comb begin
    inputActive = 1'b0;
    outputActive = 1'b0;
    case (mode)
      ddr_pkg::MODE_INPUT: begin
        inputActive = 1'b1;
      end
      ddr_pkg::MODE_OUTPUT: begin
        outputActive = 1'b1;
      end
      ddr_pkg::MODE_BIDIR: begin
        inputActive = 1'b1;
        outputActive = 1'b1;
      end
      default: begin
        inputActive = 1'b0;
        outputActive = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Read strobe qualification
  // ----------------------------------------------------------------
  // The strobe arrives from the pin, so it is synchronised before its edge
  // is looked for; this costs latency but keeps one clock domain.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      strobeSync_r <= '0;
    end else begin
      strobeSync_r <= {strobeSync_r[ddr_pkg::SYNC_STAGES-1:0], strobeIn};
    end
  end

  assign strobeEdge = strobeSync_r[ddr_pkg::SYNC_STAGES] ^ strobeSync_r[ddr_pkg::SYNC_STAGES-1];

  // Without phase-shift support the strobe is dropped and the clock rules.
  always_comb begin
    if (STROBE_ALLOWED && useStrobe) begin
      captureEn = ceIn && inputActive && strobeEdge;
    end else begin
      captureEn = ceIn && inputActive;
    end
  end

  // ----------------------------------------------------------------
  // Input capture registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      riseCap_r <= RST_WORD;
    end else if (syncClear) begin
      riseCap_r <= RST_WORD;
    end else begin
      riseCap_r <= padIn;
    end
  end

  always_ff @(negedge clk or negedge resetn) begin
    if (!resetn) begin
      fallCap_r <= RST_WORD;
    end else if (syncClear) begin
      fallCap_r <= RST_WORD;
    end else begin
      fallCap_r <= padIn;
    end
  end

  // The hold stage takes the rising capture at the falling edge and keeps it
  // through the low phase, which is what a high-transparent latch does
  // at its output, but without a real latch in the netlist.
  always_ff @(negedge clk or negedge resetn) begin
    if (!resetn) begin
      highHold_r <= RST_WORD;
    end else if (syncClear) begin
      highHold_r <= RST_WORD;
    end else if (LATCH_ALLOWED) begin
      highHold_r <= riseCap_r;
    end else begin
      highHold_r <= RST_WORD;
    end
  end

  // ----------------------------------------------------------------
  // Alignment to one edge
  // ----------------------------------------------------------------
  // Falling alignment: both bits are ready at the falling edge.
  // Rising alignment: one more rising register gathers both.
  assign alignEn = captureEn;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      alignFirst_r <= RST_WORD;
    end else if (syncClear) begin
      alignFirst_r <= RST_WORD;
    end else begin
      alignFirst_r <= ALIGN_FALLING ? pairFirst_r : highHold_r;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      alignSecond_r <= RST_WORD;
    end else if (syncClear) begin
      alignSecond_r <= RST_WORD;
    end else begin
      alignSecond_r <= ALIGN_FALLING ? pairSecond_r : fallCap_r;
    end
  end

  always_ff @(negedge clk or negedge resetn) begin
    if (!resetn) begin
      pairFirst_r <= RST_WORD;
    end else if (syncClear) begin
      pairFirst_r <= RST_WORD;
    end else begin
      pairFirst_r <= riseCap_r;
    end
  end

  always_ff @(negedge clk or negedge resetn) begin
    if (!resetn) begin
      pairSecond_r <= RST_WORD;
    end else if (syncClear) begin
      pairSecond_r <= RST_WORD;
    end else begin
      pairSecond_r <= padIn;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pairValid_r <= 1'b0;
    end else if (syncClear) begin
      pairValid_r <= 1'b0;
    end else begin
      pairValid_r <= alignEn;
    end
  end

  assign rdFirst = alignFirst_r;
  assign rdSecond = alignSecond_r;
  assign rdValid = pairValid_r;

  // ----------------------------------------------------------------
  // Output buffering
  // ----------------------------------------------------------------
  ddr_fifo #(
    .WIDTH(2 * WIDTH),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk(clk),
    .resetn(resetn),
    .wrValid(wrValid),
    .wrReady(wrReady),
    .wrData({wrFirst, wrSecond}),
    .rdValid(fifoValid),
    .rdReady(fifoReady),
    .rdData(fifoData)
  );

  // A low output clock enable stalls the FIFO, so the registers keep their
  // words and the writer sees the FIFO fill and ready fall.
  assign fifoReady = ceOut && outputActive && (dirState_r != ddr_pkg::DIR_TURN);
  assign outLoad = fifoReady && fifoValid;

  // ----------------------------------------------------------------
  // Bus direction
  // ----------------------------------------------------------------
  // Drive is requested while data flow; one idle cycle separates a burst
  // end from the next use so the enable drops before reads return.
  always_comb begin
    dirState_nxt = dirState_r;
    case (dirState_r)
      ddr_pkg::DIR_IDLE: begin
        if (outLoad) begin
          dirState_nxt = ddr_pkg::DIR_DRIVE;
        end
      end
      ddr_pkg::DIR_DRIVE: begin
        if (!outLoad) begin
          dirState_nxt = ddr_pkg::DIR_TURN;
        end
      end
      ddr_pkg::DIR_TURN: begin
        dirState_nxt = ddr_pkg::DIR_IDLE;
      end
      default: begin
        dirState_nxt = ddr_pkg::DIR_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dirState_r <= ddr_pkg::DIR_IDLE;
    end else if (syncClear) begin
      dirState_r <= ddr_pkg::DIR_IDLE;
    end else begin
      dirState_r <= dirState_nxt;
    end
  end

  // The tristate control may be inverted once per cell.
  assign triActive = OE_ACTIVE_LOW ? !triCtl : triCtl;
  assign driveReq = outputActive && triActive && (outLoad || dirState_r == ddr_pkg::DIR_DRIVE);

  ddr_out_stage #(
    .WIDTH(WIDTH),
    .RESET_VALUE(RST_BIT)
  ) u_out (
    .clk(clk),
    .resetn(resetn),
    .syncClear(syncClear),
    .load(outLoad),
    .firstBit(fifoData[2*WIDTH-1:WIDTH]),
    .secondBit(fifoData[WIDTH-1:0]),
    .driveReq(driveReq),
    .pinOut(stageOut),
    .driveNow(driveNow)
  );

  assign padOut = stageOut;
  assign padOeN = !driveNow;
  assign driving = driveNow;

endmodule

// ---- dv/ddr_io_register_path_props.sv ----
// Purpose: Port-level assertions for the double-data-rate pin register cell.
// Assumes: Default build: data pin, clear on reset, tristate active high.
// Notes: Sampled on the rising edge, so padOut is seen in its low phase.
`timescale 1ns/10ps
module ddr_io_register_path_props #(
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic syncClear,
  input wire logic [1:0] pinMode,
  input wire logic [WIDTH-1:0] padIn,
  input wire logic [WIDTH-1:0] padOut,
  input wire logic padOeN,
  input wire logic strobeIn,
  input wire logic useStrobe,
  input wire logic ceIn,
  input wire logic ceOut,
  input wire logic triCtl,
  input wire logic wrValid,
  input wire logic wrReady,
  input wire logic [WIDTH-1:0] wrFirst,
  input wire logic [WIDTH-1:0] wrSecond,
  input wire logic [WIDTH-1:0] rdFirst,
  input wire logic [WIDTH-1:0] rdSecond,
  input wire logic rdValid,
  input wire logic driving
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // A change of the enable on the rising edge would show up against this copy.
  logic oeAtRise_r;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      oeAtRise_r <= 1'b1;
    end else begin
      oeAtRise_r <= padOeN;
    end
  end

  a_oe_fall_edge: assert property (@(negedge clk) disable iff (!resetn) padOeN == oeAtRise_r)
    else $error("output enable changed away from the falling edge");
  a_drive_mirror: assert property (driving == !padOeN)
    else $error("driving flag disagrees with the pin enable");
  a_nocap_idle: assert property (!ceIn |=> !rdValid)
    else $error("capture reported with the input enable low");
  a_nocap_out: assert property (pinMode == ddr_pkg::MODE_OUTPUT |=> !rdValid)
    else $error("capture reported in output mode");
  a_hold_pin: assert property (!ceOut && !syncClear |=> $stable(padOut))
    else $error("output registers changed with the clock enable low");
  a_full_stall: assert property (!ceOut && !wrReady && !syncClear |=> !wrReady)
    else $error("full buffer drained while output was stalled");
  a_ready_keep: assert property (wrReady && !wrValid |=> wrReady)
    else $error("write ready dropped without a write");
  a_oe_quiet: assert property (!triCtl [*3] |-> padOeN)
    else $error("pin driven with the tristate control inactive");
  a_sync_clear: assert property (syncClear [*2] |-> padOeN)
    else $error("synchronous clear left the pin driven");

  c_read: cover property (rdValid);
  c_full: cover property (!wrReady);
  c_drive: cover property ($fell(padOeN));
endmodule

bind ddr_io_register_path ddr_io_register_path_props #(.WIDTH(WIDTH)) props (
  .clk(clk), .resetn(resetn), .syncClear(syncClear), .pinMode(pinMode), .padIn(padIn),
  .padOut(padOut), .padOeN(padOeN), .strobeIn(strobeIn), .useStrobe(useStrobe), .ceIn(ceIn),
  .ceOut(ceOut), .triCtl(triCtl), .wrValid(wrValid), .wrReady(wrReady), .wrFirst(wrFirst),
  .wrSecond(wrSecond), .rdFirst(rdFirst), .rdSecond(rdSecond), .rdValid(rdValid), .driving(driving)
);

// ---- dv/ddr_mem_model.sv ----
// Purpose: Behavioural memory on the far side of the pin cell.
// Assumes: Read data straddle the clock edge that should capture them.
// Notes: Received pairs are kept in gotQ; repeats of a held pair are dropped.
`timescale 1ns/10ps
module ddr_mem_model #(
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic drv,
  input wire logic [WIDTH-1:0] srcFirst,
  input wire logic [WIDTH-1:0] srcSecond,
  input wire logic [WIDTH-1:0] padOut,
  input wire logic padOeN,
  output logic [WIDTH-1:0] dq,
  output logic dqs
);
  // ----------------------------------------------------------------
  // Read drive and write capture
  // ----------------------------------------------------------------
  logic [2*WIDTH-1:0] gotQ[$];
  logic [2*WIDTH-1:0] lastPair = '1;
  logic [WIDTH-1:0] hiBit = '0;

  initial begin
    dq = '0;
    dqs = 1'b0;
  end

  // A released bus keeps changing so a stale value can never look right.
  always @(posedge clk) begin
    #2.5;
    hiBit = padOut;
    dq = drv ? srcSecond : ~dq;
    dqs = drv;
  end

  always @(negedge clk) begin
    #2.5;
    if (!padOeN && {hiBit, padOut} != lastPair) begin
      lastPair = {hiBit, padOut};
      gotQ.push_back(lastPair);
    end
    dq = drv ? srcFirst : ~dq;
    dqs = 1'b0;
  end
endmodule

// ---- dv/ddr_io_register_path_tb.sv ----
// Purpose: Self-checking bench for the pin register cell and its memory partner.
// Assumes: Default build of the cell; clk 100 MHz.
// Notes: The two-way pin is resolved here from the cell's enable.
`timescale 1ns/10ps
module ddr_io_register_path_tb;
  // ----------------------------------------------------------------
  // Bench
  // ----------------------------------------------------------------
  localparam int W = ddr_pkg::PIN_WIDTH;
  logic clk = 1'b0;
  logic resetn, syncClear, padOeN, useStrobe, ceIn, ceOut, triCtl;
  logic wrValid, wrReady, rdValid, driving, memDrv, dqs;
  logic [1:0] pinMode;
  logic [W-1:0] padIn, padOut, wrFirst, wrSecond, rdFirst, rdSecond, srcFirst, srcSecond, dq;
  int err_total = 0;
  int checks = 0;
  int cycles = 0;

  always #5 clk = ~clk;
  assign padIn = !padOeN ? padOut : dq;

  ddr_io_register_path #(.WIDTH(W), .DEPTH(ddr_pkg::FIFO_DEPTH)) dut (
    .clk(clk), .resetn(resetn), .syncClear(syncClear), .pinMode(pinMode), .padIn(padIn),
    .padOut(padOut), .padOeN(padOeN), .strobeIn(dqs), .useStrobe(useStrobe), .ceIn(ceIn),
    .ceOut(ceOut), .triCtl(triCtl), .wrValid(wrValid), .wrReady(wrReady), .wrFirst(wrFirst),
    .wrSecond(wrSecond), .rdFirst(rdFirst), .rdSecond(rdSecond), .rdValid(rdValid), .driving(driving)
  );

  ddr_mem_model #(.WIDTH(W)) mem (
    .clk(clk), .drv(memDrv), .srcFirst(srcFirst), .srcSecond(srcSecond),
    .padOut(padOut), .padOeN(padOeN), .dq(dq), .dqs(dqs)
  );

  task automatic print_verdict();
    if (err_total == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      print_verdict();
    end
  end

  task automatic wrPair(input logic [W-1:0] f, input logic [W-1:0] s, output logic ok);
    wrValid <= 1'b1;
    wrFirst <= f;
    wrSecond <= s;
    @(negedge clk);
    ok = wrReady;
    @(posedge clk);
  endtask

  // The memory holds one pair on the pin; the capture path needs three edges (rising, falling, rising) to show it.
  task automatic readPair(input logic [W-1:0] a, input logic [W-1:0] b);
    srcFirst <= a;
    srcSecond <= b;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk(16'(rdValid), 16'h0001);
    chk({rdFirst, rdSecond}, {a, b});
    @(posedge clk);
  endtask

  task automatic chkGot(input int n0, input logic [15:0] want[$]);
    chk(16'(mem.gotQ.size() - n0), 16'(want.size()));
    foreach (want[i]) begin
      if (n0 + i < mem.gotQ.size()) chk(mem.gotQ[n0 + i], want[i]);
    end
  endtask

  task automatic t_input();
    pinMode <= ddr_pkg::MODE_INPUT;
    ceIn <= 1'b1;
    useStrobe <= 1'b1;
    memDrv <= 1'b1;
    readPair(8'ha5, 8'h3c);
    readPair(8'h0f, 8'hf0);
    syncClear <= 1'b1;
    repeat (2) @(posedge clk);
    syncClear <= 1'b0;
    ceIn <= 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk(16'(rdValid), 16'h0000);
    chk(16'(padOeN), 16'h0001);
    @(posedge clk);
    memDrv <= 1'b0;
    ceIn <= 1'b1;
  endtask

  task automatic t_output();
    logic ok;
    int n0;
    logic [15:0] want[$];
    pinMode <= ddr_pkg::MODE_OUTPUT;
    triCtl <= 1'b1;
    @(posedge clk);
    n0 = mem.gotQ.size();
    for (int k = 0; k < 3; k++) begin
      wrPair(8'(8'h11 + 8'h22 * k), 8'(8'h22 + 8'h22 * k), ok);
      chk(16'(ok), 16'h0001);
      want.push_back({8'(8'h11 + 8'h22 * k), 8'(8'h22 + 8'h22 * k)});
    end
    wrValid <= 1'b0;
    repeat (10) @(posedge clk);
    chkGot(n0, want);
  endtask

  task automatic t_stall();
    logic ok;
    int cnt;
    int n0;
    logic [15:0] want[$];
    cnt = 0;
    ceOut <= 1'b0;
    @(posedge clk);
    n0 = mem.gotQ.size();
    for (int k = 0; k < 10; k++) begin
      wrPair(8'(8'h80 + k), 8'(8'hc0 + k), ok);
      if (!ok) break;
      want.push_back({8'(8'h80 + k), 8'(8'hc0 + k)});
      cnt++;
    end
    wrValid <= 1'b0;
    repeat (4) @(posedge clk);
    chk(16'(cnt), 16'(ddr_pkg::FIFO_DEPTH));
    chk(16'(mem.gotQ.size()), 16'(n0));
    ceOut <= 1'b1;
    repeat (20) @(posedge clk);
    chkGot(n0, want);
  endtask

  task automatic t_bidir();
    logic ok;
    int n0;
    logic [15:0] want[$];
    pinMode <= ddr_pkg::MODE_BIDIR;
    memDrv <= 1'b1;
    readPair(8'hc3, 8'h5a);
    memDrv <= 1'b0;
    n0 = mem.gotQ.size();
    wrPair(8'hd1, 8'he2, ok);
    wrValid <= 1'b0;
    want.push_back(16'hd1e2);
    repeat (8) @(posedge clk);
    chkGot(n0, want);
    n0 = mem.gotQ.size();
    triCtl <= 1'b0;
    wrPair(8'h4b, 8'hb4, ok);
    wrValid <= 1'b0;
    repeat (8) @(posedge clk);
    chk(16'(mem.gotQ.size() - n0), 16'h0000);
    pinMode <= ddr_pkg::MODE_OFF;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk(16'({rdValid, padOeN}), 16'h0001);
  endtask

  initial begin
    resetn = 1'b0;
    syncClear = 1'b0;
    pinMode = ddr_pkg::MODE_OFF;
    useStrobe = 1'b0;
    ceIn = 1'b0;
    ceOut = 1'b1;
    triCtl = 1'b0;
    wrValid = 1'b0;
    wrFirst = '0;
    wrSecond = '0;
    memDrv = 1'b0;
    srcFirst = '0;
    srcSecond = '0;
    repeat (10) @(posedge clk);
    @(negedge clk);
    chk({14'h0000, padOeN, driving}, 16'h0002);
    chk({14'h0000, rdValid, wrReady}, 16'h0001);
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    t_input();
    t_output();
    t_stall();
    t_bidir();
    print_verdict();
  end
endmodule
